// file: rpg_pkg.sv
package rpg_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned START_WAIT_NS = 500;
    localparam int unsigned START_WAIT_CYC =
        (START_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [CNT_W-1:0] CNT_DONE  = CNT_W'(START_WAIT_CYC);

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        RPG_ST_RESET,
        RPG_ST_SETTLE,
        RPG_ST_RUN
    } rpg_state_t;
endpackage : rpg_pkg

// file: rpg_sync.sv
`timescale 1ns/100ps
module rpg_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             clear_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] clear_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ****************************************
    // Two-stage synchroniser, async clear
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clock_i or negedge clear_n_i) begin
                if (!clear_n_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q ^ clear_val_i;
endmodule : rpg_sync

// file: rpg_gate.sv
`timescale 1ns/100ps
module rpg_gate
    import rpg_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic clk_en_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      core_resetn_o,
    output logic      port_enable_o,
    output logic      audio_enable_o,
    output logic      scl_o,
    output logic      sda_o,
    output logic      start_early_o
);
    import rpg_pkg::*;

    typedef struct packed {
        rpg_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic             sda_prev;
        logic             early;
    } rpg_regs_t;

    rpg_regs_t r_q;
    rpg_regs_t r_d;
    logic      rel_n;
    logic [1:0] pins;
    logic      start_seen;

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    rpg_sync #(.WIDTH(1)) u_rst_sync (
        .clock_i     (clock_i),
        .clear_n_i   (resetn_i),
        .async_i     (1'b1),
        .clear_val_i (1'b0),
        .sync_o      (rel_n)
    );

    // Idle level of bus is high; synchronisers clear to low, so invert around them
    rpg_sync #(.WIDTH(2)) u_pin_sync (
        .clock_i     (clock_i),
        .clear_n_i   (resetn_i),
        .async_i     ({~scl_i, ~sda_i}),
        .clear_val_i (2'h3),
        .sync_o      (pins)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    assign start_seen = pins[1] && r_q.sda_prev && !pins[0];

    always_comb begin
        r_d = r_q;
        r_d.sda_prev = pins[0];
        unique case (r_q.state)
            RPG_ST_RESET: begin
                r_d.state = RPG_ST_SETTLE;
                r_d.cnt   = CNT_RESET;
            end
            RPG_ST_SETTLE: begin
                if (start_seen) begin
                    r_d.early = 1'b1;
                end
                if (r_q.cnt == CNT_DONE) begin
                    r_d.state = RPG_ST_RUN;
                end else begin
                    r_d.cnt = r_q.cnt + 6'h01;
                end
            end
            RPG_ST_RUN: begin
                r_d.state = RPG_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rel_n) begin
        if (!rel_n) begin
            r_q.state    <= RPG_ST_RESET;
            r_q.cnt      <= CNT_RESET;
            r_q.sda_prev <= 1'b1;
            r_q.early    <= 1'b0;
        end else if (clk_en_i) begin
            r_q <= r_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign core_resetn_o  = rel_n;
    assign port_enable_o  = rel_n && (r_q.state != RPG_ST_RESET);
    assign audio_enable_o = rel_n && (r_q.state == RPG_ST_RUN);
    assign scl_o          = port_enable_o ? pins[1] : 1'b1;
    assign sda_o          = port_enable_o ? pins[0] : 1'b1;
    assign start_early_o  = r_q.early;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_release;
        $rose(rel_n);
    endsequence

    no_port_reset_a: assert property (@(posedge clock_i)
        !resetn_i |-> !port_enable_o && !audio_enable_o)
        else $error("port open during reset");

    run_after_wait_a: assert property (@(posedge clock_i) disable iff (!rel_n || !clk_en_i)
        $rose(audio_enable_o) |-> $past(r_q.cnt) == CNT_DONE)
        else $error("audio enabled before settle count");

    release_two_a: assert property (@(posedge clock_i)
        !resetn_i ##1 resetn_i [*2] |-> !rel_n)
        else $error("reset released too early");

    release_state_a: assert property (@(posedge clock_i)
        s_release |-> r_q.state == RPG_ST_RESET)
        else $error("state not default at release");

    port_stays_a: assert property (@(posedge clock_i) disable iff (!rel_n)
        port_enable_o |=> port_enable_o)
        else $error("port closed without reset");

    only_pin_a: assert property (@(posedge clock_i)
        resetn_i && $past(resetn_i) && $past(resetn_i, 2) |-> rel_n)
        else $error("reset without pin");

    // ****************************************
    // Sequencer and pin checks
    // ****************************************
    sequence s_frozen;
        rel_n && !clk_en_i;
    endsequence

    sequence s_count_step;
        clk_en_i && (r_q.state == RPG_ST_SETTLE) && (r_q.cnt != CNT_DONE);
    endsequence

    sequence s_count_end;
        clk_en_i && (r_q.state == RPG_ST_SETTLE) && (r_q.cnt == CNT_DONE);
    endsequence

    sequence s_port_steady;
        port_enable_o [*4];
    endsequence

    freeze_hold_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        s_frozen |=> r_q == $past(r_q))
        else $error("state moved while enable low");

    count_step_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        s_count_step |=> r_q.cnt == $past(r_q.cnt) + 6'h01)
        else $error("settle count skipped");

    count_end_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        s_count_end |=> r_q.state == RPG_ST_RUN)
        else $error("run not entered at count end");

    run_holds_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        (r_q.state == RPG_ST_RUN) |=> (r_q.state == RPG_ST_RUN))
        else $error("run state left without reset");

    early_sticky_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        start_early_o |=> start_early_o)
        else $error("early flag cleared without reset");

    early_cause_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        $rose(start_early_o) |-> $past(r_q.state) == RPG_ST_SETTLE)
        else $error("early flag set outside settle");

    pins_forced_a: assert property (
        @(posedge clock_i)
        !port_enable_o |-> scl_o && sda_o)
        else $error("pins not idle while port closed");

    scl_delay_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        s_port_steady |-> scl_o == $past(scl_i, 2))
        else $error("clock pin not passed after two edges");

    sda_delay_a: assert property (
        @(posedge clock_i) disable iff (!rel_n)
        s_port_steady |-> sda_o == $past(sda_i, 2))
        else $error("data pin not passed after two edges");

    core_follow_a: assert property (
        @(posedge clock_i)
        !resetn_i |-> !core_resetn_o)
        else $error("core reset not following pin");

    reset_regs_a: assert property (
        @(posedge clock_i)
        !rel_n |-> (r_q.state == RPG_ST_RESET) && !r_q.early && (r_q.cnt == CNT_RESET))
        else $error("state not default in reset");

    audio_port_a: assert property (
        @(posedge clock_i)
        audio_enable_o |-> port_enable_o)
        else $error("audio open while port closed");
endmodule : rpg_gate

// file: rpg_host.sv
`timescale 1ns/100ps
module rpg_host (
    input  wire logic clock_i,
    output logic      resetn_o,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        resetn_o = 1'b0;
        scl_o    = 1'b1;
        sda_o    = 1'b1;
    end
    task automatic hold_reset(input int n);
        resetn_o = 1'b0;
        repeat (n) @(negedge clock_i);
        resetn_o = 1'b1;
    endtask : hold_reset
    task automatic start_cond(input int wait_cyc);
        repeat (wait_cyc) @(negedge clock_i);
        sda_o = 1'b0;
        repeat (4) @(negedge clock_i);
        sda_o = 1'b1;
    endtask : start_cond
    task automatic scl_pulse(input int n);
        scl_o = 1'b0;
        repeat (n) @(negedge clock_i);
        scl_o = 1'b1;
    endtask : scl_pulse
endmodule : rpg_host

// file: tb.sv
`timescale 1ns/100ps
module tb;
    import rpg_pkg::*;
    logic clock_i = 1'b0;
    logic clk_en  = 1'b1;
    logic resetn, scl, sda, core_rn, port_en, aud_en, scl_s, sda_s, early;
    int   err_total = 0;
    int   tests_run = 0;
    initial forever #12.5 clock_i = ~clock_i;
    rpg_host u_rpg_host (.clock_i(clock_i), .resetn_o(resetn), .scl_o(scl), .sda_o(sda));
    rpg_gate u_rpg_gate (.clock_i(clock_i), .resetn_i(resetn), .clk_en_i(clk_en),
        .scl_i(scl), .sda_i(sda), .core_resetn_o(core_rn), .port_enable_o(port_en),
        .audio_enable_o(aud_en), .scl_o(scl_s), .sda_o(sda_s), .start_early_o(early));
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic release_walk();
        u_rpg_host.hold_reset(3);
        for (int k = 1; k <= 26; k++) begin
            @(negedge clock_i);
            chk(core_rn, k >= 2);
            chk(port_en, k >= 3);
            chk(aud_en, k >= START_WAIT_CYC + 4);
            chk(scl_s, 1'b1);
        end
    endtask : release_walk
    task automatic valid_start();
        fork
            u_rpg_host.start_cond(0);
            begin
                @(negedge clock_i);
                chk(sda_s, 1'b1);
                @(negedge clock_i);
                chk(sda_s, 1'b0);
                chk(early, 1'b0);
            end
        join
    endtask : valid_start
    task automatic early_start();
        u_rpg_host.hold_reset(3);
        u_rpg_host.start_cond(4);
        repeat (30) @(negedge clock_i);
        chk(early, 1'b1);
    endtask : early_start
    task automatic async_reset();
        clk_en = 1'b0;
        fork
            u_rpg_host.hold_reset(3);
            begin
                #1;
                chk(core_rn, 1'b0);
                chk(port_en, 1'b0);
                chk(aud_en, 1'b0);
                chk(sda_s, 1'b1);
                chk(early, 1'b0);
            end
        join
        repeat (10) @(negedge clock_i);
        chk(core_rn, 1'b1);
        chk(port_en, 1'b0);
        clk_en = 1'b1;
        for (int k = 1; k <= 22; k++) begin
            @(negedge clock_i);
            chk(port_en, 1'b1);
            chk(aud_en, k >= START_WAIT_CYC + 2);
        end
    endtask : async_reset
    task automatic scl_follow();
        fork
            u_rpg_host.scl_pulse(4);
            begin
                @(negedge clock_i);
                chk(scl_s, 1'b1);
                @(negedge clock_i);
                chk(scl_s, 1'b0);
            end
        join
        repeat (2) @(negedge clock_i);
        chk(scl_s, 1'b1);
    endtask : scl_follow
    initial begin
        release_walk();
        valid_start();
        early_start();
        async_reset();
        scl_follow();
        final_report();
    end
endmodule : tb
